//--- inc/sprx_pkg.sv
// sprx_pkg: shared constants and types of the receiver input front end.
// assumes: one 25 MHz master clock; registers reached over the internal
// byte-wide register port of the control interface.
package sprx_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INPUT_SELECT = 8'h08;
  localparam logic [7:0] OFF_INPUT_MODE = 8'h09;
  localparam logic [7:0] OFF_RX_CONFIG = 8'h1C;
  localparam logic [7:0] OFF_POWER_DOWN = 8'h1E;

  localparam int SEL_MSB = 2;
  localparam int BIT_UPPER_AS_OUT = 5;
  localparam int BIT_TRUNC_MASK = 6;
  localparam int BIT_HIGH_RATE = 7;
  localparam int BIT_RX_POWER_DOWN = 1;

  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_INPUT_MODE = 8'hFF;
  localparam logic [7:0] RST_RX_CONFIG = 8'h80;
  localparam logic [7:0] RST_POWER_DOWN = 8'h02;

  // ----------------------------------------------------------------
  // sub-frame layout (slots after the preamble)
  // ----------------------------------------------------------------
  localparam logic [4:0] WORD_BITS = 5'd24;
  localparam logic [4:0] LAST_SLOT = 5'd27;
  localparam int SLOT_V = 24;
  localparam int SLOT_U = 25;
  localparam int SLOT_C = 26;
  localparam int SLOT_P = 27;
  localparam logic [2:0] PRE_HALF_CELLS = 3'd5;

  // channel-status bit positions of interest, block length
  localparam logic [7:0] CS_NON_PCM = 8'd1;
  localparam logic [7:0] CS_MAX_WL = 8'd32;
  localparam logic [7:0] CS_WL_LO = 8'd33;
  localparam logic [7:0] CS_WL_HI = 8'd35;
  localparam logic [7:0] CS_LAST_FRAME = 8'd191;

  // ----------------------------------------------------------------
  // edge interval classification, in mclk cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] T1_MAX = 8'd3;
  localparam logic [7:0] T2_MAX = 8'd5;
  localparam logic [7:0] T3_MAX = 8'd7;
  localparam logic [7:0] MIN_CNT_96 = 8'd2;
  localparam logic [7:0] CNT_TIMEOUT = 8'hFF;

  typedef enum {PRE_B, PRE_M, PRE_W} sprx_pre_type;

  typedef struct packed {
    logic [23:0] audio;
    logic validity;
    logic user;
    logic chanStatus;
    logic parity;
    logic parityErr;
    logic secondChan;
    logic blockStart;
  } sprx_subframe_type;

endpackage

//--- hdl/sprx_two_buf.sv
// sprx_two_buf: two-entry buffer with valid/ready on both sides.
// assumes: both sides on the same clock; data held in flops.
`timescale 1ns/1ps
module sprx_two_buf #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  import sprx_pkg::*;

  logic [WIDTH-1:0] mem_r [2];
  logic wrPtr_r;
  logic rdPtr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  assign inReady = (count_r != 2'd2);
  assign outValid = (count_r != 2'd0);
  assign outData = mem_r[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'd0;
    end else begin
      if (push) wrPtr_r <= ~wrPtr_r;
      if (pop) rdPtr_r <= ~rdPtr_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk) begin
    if (push) mem_r[wrPtr_r] <= inData;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_buf_full_blocks;
    @(posedge mclk) disable iff (rst)
    (!inReady && !pop) |=> (!inReady && outData == $past(outData));
  endproperty
  a_buf_full_blocks: assert property (p_buf_full_blocks)
    else $error("full buffer changed its head word without a pop");

  property p_buf_order;
    @(posedge mclk) disable iff (rst)
    (push && count_r == 2'd0 && !pop) |=> (outValid && outData == $past(inData));
  endproperty
  a_buf_order: assert property (p_buf_order)
    else $error("buffer head differs from word written into empty buffer");

  c_buf_fills: cover property (@(posedge mclk) disable iff (rst)
    count_r == 2'd2);
endmodule

//--- hdl/sprx_front_end.sv
// sprx_front_end: receive pins, input select, bi-phase decoder, sub-frame
// extraction, word-length truncation and routing of received words.
// assumes: receive pins are asynchronous; register port strobes come from
// the control interface on mclk.
//
// Contract
// - each input-mode bit picks CMOS (0) or comparator (1) for its input, all ones at reset.
// - the upper-input repurpose bit turns inputs 4 to 7 into driven outputs, off at reset.
// - the 3-bit input select passes input n to the decoder (held low for n of 4 to 7 while those are outputs), 000 at reset.
// - the power-down bit disables the receiver when set and resets set.
// - a power-down requested mid-frame takes effect only after the current frame ends while locked, at once when not locked.
// - with the truncation mask clear words are cut to the indicated length, else passed whole.
// - the high-rate bit allows 192 kHz when set (reset) and limits to 96 kHz when clear.
// - every sub-frame yields its audio word and validity, user, status and parity bits.
// - a stream marked as not linear PCM is detected and flagged.
// - received words go either to the audio interface or to the retransmit output.
// - 24 bits are always captured and excess low bits are cleared when the length is shorter and the truncation mask is clear.
`timescale 1ns/1ps
module sprx_front_end (
  input wire logic mclk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [7:0] rxPinIn,
  output logic [7:0] rxPinOut,
  output logic [7:0] rxPinOe,
  input wire logic [3:0] gpoLevel,
  output logic [7:0] inputModeComparator,
  input wire logic routeToTx,
  output logic aifValid,
  input wire logic aifReady,
  output logic txValid,
  input wire logic txReady,
  output sprx_pkg::sprx_subframe_type wordOut,
  output logic rxPowered,
  output logic locked,
  output logic nonPcm,
  output logic [4:0] wordLength,
  output logic overrun
);
  import sprx_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] unitsOf(input logic [7:0] c,
                                         input logic hr);
    if (!hr && c < MIN_CNT_96) return 2'd0;
    if (c <= T1_MAX) return 2'd1;
    if (c <= T2_MAX) return 2'd2;
    if (c <= T3_MAX) return 2'd3;
    return 2'd0;
  endfunction

  function automatic logic [4:0] lenOf(input logic mx, input logic [2:0] wl);
    case (wl)
      3'b001: return mx ? 5'd20 : 5'd16;
      3'b010: return mx ? 5'd22 : 5'd18;
      3'b100: return mx ? 5'd23 : 5'd19;
      3'b101: return mx ? 5'd24 : 5'd20;
      3'b110: return mx ? 5'd21 : 5'd17;
      default: return WORD_BITS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0] selReg_r;
  logic [7:0] modeReg_r;
  logic [7:0] cfgReg_r;
  logic pdReg_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      selReg_r <= RST_INPUT_SELECT[SEL_MSB:0];
      modeReg_r <= RST_INPUT_MODE;
      cfgReg_r <= RST_RX_CONFIG;
      pdReg_r <= RST_POWER_DOWN[BIT_RX_POWER_DOWN];
    end else if (regWrite) begin
      unique case (regAddr)
        OFF_INPUT_SELECT: selReg_r <= regWdata[SEL_MSB:0];
        OFF_INPUT_MODE: modeReg_r <= regWdata;
        OFF_RX_CONFIG: cfgReg_r <= regWdata & 8'hE0;
        OFF_POWER_DOWN: pdReg_r <= regWdata[BIT_RX_POWER_DOWN];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        OFF_INPUT_SELECT: regRdata <= {5'h00, selReg_r};
        OFF_INPUT_MODE: regRdata <= modeReg_r;
        OFF_RX_CONFIG: regRdata <= cfgReg_r;
        OFF_POWER_DOWN: regRdata <= {6'h00, pdReg_r, 1'b0};
        default: regRdata <= 8'h00;
      endcase
    end
  end

  logic upperOut;
  logic truncMasked;
  logic highRate;
  assign upperOut = cfgReg_r[BIT_UPPER_AS_OUT];
  assign truncMasked = cfgReg_r[BIT_TRUNC_MASK];
  assign highRate = cfgReg_r[BIT_HIGH_RATE];

  // ----------------------------------------------------------------
  // pins and input select
  // ----------------------------------------------------------------
  assign inputModeComparator = modeReg_r;
  assign rxPinOe = {{4{upperOut}}, 4'h0};
  assign rxPinOut = {upperOut ? gpoLevel : 4'h0, 4'h0};

  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= rxPinIn;
      sync2_r <= sync1_r;
    end
  end

  logic muxLine;
  assign muxLine = (upperOut && selReg_r[2]) ? 1'b0 : sync2_r[selReg_r];

  // ----------------------------------------------------------------
  // bi-phase decoder
  // ----------------------------------------------------------------
  typedef enum {HUNT, PRE, DATA} sprx_dec_type;
  sprx_dec_type state_r;
  sprx_pre_type preKind_r;
  logic rxOn_r;
  logic line_r;
  logic [7:0] ivCnt_r;
  logic [2:0] preAcc_r;
  logic [4:0] slot_r;
  logic half_r;
  logic [27:0] sh_r;
  logic edgeSeen;
  logic [1:0] units;
  logic bitDone;
  logic bitVal;
  logic done;
  logic frameEnd;
  logic [27:0] shNext;

  assign edgeSeen = rxOn_r && (muxLine != line_r);
  assign units = unitsOf(ivCnt_r, highRate);
  assign bitDone = edgeSeen && state_r == DATA &&
                   ((units == 2'd2 && !half_r) || (units == 2'd1 && half_r));
  assign bitVal = half_r;
  assign shNext = {bitVal, sh_r[27:1]};
  assign done = bitDone && slot_r == LAST_SLOT;
  assign frameEnd = done && preKind_r == PRE_W;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      line_r <= 1'b0;
      ivCnt_r <= 8'h00;
    end else begin
      line_r <= muxLine;
      if (edgeSeen) ivCnt_r <= 8'h00;
      else if (ivCnt_r != CNT_TIMEOUT) ivCnt_r <= ivCnt_r + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= HUNT;
      preKind_r <= PRE_B;
      preAcc_r <= 3'd0;
      slot_r <= 5'd0;
      half_r <= 1'b0;
      sh_r <= 28'h0000000;
    end else if (!rxOn_r || ivCnt_r == CNT_TIMEOUT) begin
      state_r <= HUNT;
    end else if (edgeSeen) begin
      unique case (state_r)
        HUNT: begin
          if (units == 2'd3) begin
            state_r <= PRE;
            preAcc_r <= 3'd0;
          end
        end
        PRE: begin
          if (preAcc_r == 3'd0) begin
            unique case (units)
              2'd1: preKind_r <= PRE_B;
              2'd2: preKind_r <= PRE_W;
              default: preKind_r <= PRE_M;
            endcase
          end
          if (units == 2'd0 || preAcc_r + {1'b0, units} > PRE_HALF_CELLS) begin
            state_r <= HUNT;
          end else if (preAcc_r + {1'b0, units} == PRE_HALF_CELLS) begin
            state_r <= DATA;
            slot_r <= 5'd0;
            half_r <= 1'b0;
          end
          preAcc_r <= preAcc_r + {1'b0, units};
        end
        DATA: begin
          if (bitDone) begin
            sh_r <= shNext;
            half_r <= 1'b0;
            slot_r <= slot_r + 5'd1;
            if (done) state_r <= HUNT;
          end else if (units == 2'd1) begin
            half_r <= 1'b1;
          end else begin
            state_r <= HUNT;
          end
        end
      endcase
    end
  end

  // power-down waits for the frame in progress to finish while locked, else acts at once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxOn_r <= 1'b0;
      locked <= 1'b0;
    end else begin
      if (!pdReg_r) rxOn_r <= 1'b1;
      else if (!locked || frameEnd) rxOn_r <= 1'b0;
      if (!rxOn_r || ivCnt_r == CNT_TIMEOUT) locked <= 1'b0;
      else if (done) locked <= 1'b1;
    end
  end
  assign rxPowered = rxOn_r;

  // ----------------------------------------------------------------
  // channel status of the first channel
  // ----------------------------------------------------------------
  logic [7:0] frameIdx_r;
  logic [7:0] curIdx;
  logic chan1Done;
  logic max_word_length_flag_r;
  logic [2:0] wl_r;
  assign chan1Done = done && preKind_r != PRE_W;
  assign curIdx = (preKind_r == PRE_B) ? 8'd0 :
                  (frameIdx_r == CS_LAST_FRAME) ? 8'd0 : frameIdx_r + 8'd1;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frameIdx_r <= 8'd0;
      nonPcm <= 1'b0;
      max_word_length_flag_r <= 1'b0;
      wl_r <= 3'b000;
    end else if (chan1Done) begin
      frameIdx_r <= curIdx;
      if (curIdx == CS_NON_PCM) nonPcm <= shNext[SLOT_C];
      if (curIdx == CS_MAX_WL) max_word_length_flag_r <= shNext[SLOT_C];
      if (curIdx >= CS_WL_LO && curIdx <= CS_WL_HI)
        wl_r[curIdx[1:0] - 2'd1] <= shNext[SLOT_C];
    end
  end
  assign wordLength = lenOf(max_word_length_flag_r, wl_r);

  // ----------------------------------------------------------------
  // word capture, truncation and routing
  // ----------------------------------------------------------------
  sprx_subframe_type sf_r;
  logic sfValid_r;
  logic bufInReady;
  logic bufOutValid;
  logic [23:0] keepMask;
  assign keepMask = truncMasked ? 24'hFFFFFF :
                    24'hFFFFFF << (WORD_BITS - wordLength);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sfValid_r <= 1'b0;
      sf_r <= '0;
      overrun <= 1'b0;
    end else begin
      sfValid_r <= done;
      overrun <= sfValid_r && !bufInReady;
      if (done) begin
        sf_r.audio <= shNext[23:0] & keepMask;
        sf_r.validity <= shNext[SLOT_V];
        sf_r.user <= shNext[SLOT_U];
        sf_r.chanStatus <= shNext[SLOT_C];
        sf_r.parity <= shNext[SLOT_P];
        sf_r.parityErr <= ^shNext;
        sf_r.secondChan <= preKind_r == PRE_W;
        sf_r.blockStart <= preKind_r == PRE_B;
      end
    end
  end

  sprx_two_buf #(.WIDTH($bits(sprx_subframe_type))) u_buf (
    .mclk(mclk),
    .rst(rst),
    .inValid(sfValid_r),
    .inReady(bufInReady),
    .inData(sf_r),
    .outValid(bufOutValid),
    .outReady(routeToTx ? txReady : aifReady),
    .outData(wordOut)
  );
  assign aifValid = bufOutValid && !routeToTx;
  assign txValid = bufOutValid && routeToTx;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_mode_write;
    regWrite && regAddr == OFF_INPUT_MODE |=>
      inputModeComparator == $past(regWdata);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("input mode does not follow write");

  property p_upper_out;
    regWrite && regAddr == OFF_RX_CONFIG |=>
      rxPinOe == {{4{$past(regWdata[BIT_UPPER_AS_OUT])}}, 4'h0};
  endproperty
  a_upper_out: assert property (p_upper_out)
    else $error("upper pin enables wrong after config write");

  // the pin seen two edges ago reaches the decoder through both flops
  property p_select;
    !$past(rst) && !$past(rst, 2) && selReg_r == $past(selReg_r) &&
      selReg_r == $past(selReg_r, 2) |->
      muxLine == ((upperOut && selReg_r[2]) ? 1'b0 :
                  $past(rxPinIn[selReg_r], 2));
  endproperty
  a_select: assert property (p_select)
    else $error("decoder input not the selected pin");

  property p_power_on;
    $rose(rxOn_r) |-> $past(!pdReg_r);
  endproperty
  a_power_on: assert property (p_power_on)
    else $error("receiver enabled while power-down set");

  property p_pd_waits;
    pdReg_r && rxOn_r && locked && !frameEnd |=> rxOn_r;
  endproperty
  a_pd_waits: assert property (p_pd_waits)
    else $error("receiver stopped before frame end");

  // the word was cut with the length known when it was captured
  property p_trunc;
    sfValid_r && !$past(truncMasked) && $past(wordLength) == 5'd20 |->
      sf_r.audio[3:0] == 4'h0;
  endproperty
  a_trunc: assert property (p_trunc)
    else $error("excess low bits not cleared");

  property p_rate_limit;
    edgeSeen && !highRate && ivCnt_r < MIN_CNT_96 |=> state_r == HUNT;
  endproperty
  a_rate_limit: assert property (p_rate_limit)
    else $error("too short interval accepted at low rate limit");

  property p_fields;
    done |=> sfValid_r && sf_r.user == $past(shNext[SLOT_U]) &&
      sf_r.validity == $past(shNext[SLOT_V]);
  endproperty
  a_fields: assert property (p_fields)
    else $error("sub-frame flags not captured");

  property p_non_pcm;
    chan1Done && curIdx == CS_NON_PCM |=> nonPcm == $past(shNext[SLOT_C]);
  endproperty
  a_non_pcm: assert property (p_non_pcm)
    else $error("non-PCM flag not taken from status bit");

  property p_route;
    bufOutValid && !(txValid && txReady) && !(aifValid && aifReady) |=>
      bufOutValid && $stable(wordOut);
  endproperty
  a_route: assert property (p_route)
    else $error("offered word dropped before the routed side took it");

  c_frame_end: cover property (frameEnd);
  c_pd_deferred: cover property (pdReg_r && rxOn_r && locked ##1 frameEnd);
  c_non_pcm: cover property ($rose(nonPcm));
  c_tx_route: cover property (txValid && txReady);
endmodule

//--- tb/sprx_src_model.sv
// sprx_src_model: bi-phase mark source of sub-frames for one receive line.
// assumes: intervals counted in mclk cycles; the caller sends sub-frames
// back to back and calls kick before the first one after a pause.
`timescale 1ns/1ps
module sprx_src_model (
  input wire logic mclk,
  output logic line
);
  // cycles of a one-unit interval; two and three units take 5 and 7
  int u1 = 3;

  initial line = 1'h0;

  // ------------------------------------------------------------
  // line transitions
  // ------------------------------------------------------------
  task automatic hold(input int n);
    repeat ((n == 1) ? u1 : 2 * n + 1) @(posedge mclk);
    line <= ~line;
  endtask

  task automatic kick();
    @(posedge mclk);
    line <= ~line;
  endtask

  // pre is the second preamble interval: 1 = B, 3 = M, 2 = W
  task automatic send_sub(input int pre, input logic [26:0] d);
    logic [27:0] s;
    s = {^d, d};
    hold(3);
    hold(pre);
    hold(1);
    hold(4 - pre);
    for (int i = 0; i < 28; i++) begin
      if (s[i]) begin
        hold(1);
        hold(1);
      end else begin
        hold(2);
      end
    end
  endtask
endmodule

//--- tb/tb.sv
// tb: self-checking bench of the receiver input front end.
// assumes: the source model feeds the selected pin, noise on the others.
`timescale 1ns/1ps
module tb;
  import sprx_pkg::*;
  logic mclk, rst, regWrite, regRead, routeToTx, aifReady, txReady;
  logic [7:0] regAddr, regWdata, regRdata, rxPinIn, rxPinOut, rxPinOe;
  logic [7:0] inputModeComparator, v, r;
  logic [3:0] gpoLevel;
  logic aifValid, txValid, rxPowered, locked, nonPcm, overrun, line;
  logic [4:0] wordLength;
  logic [1:0] stallMode;
  sprx_subframe_type wordOut;
  sprx_subframe_type got[$], expQ[$];
  int seed = 5630, mismatches = 0, samples_checked = 0, cyc = 0;
  int pinSel = 0, overruns = 0, wrongSide = 0;
  logic [7:0] ra[5] = '{8'h08, 8'h09, 8'h1C, 8'h1E, 8'h55};
  logic [7:0] rv[5] = '{8'h00, 8'hFF, 8'h80, 8'h02, 8'h00};

  sprx_front_end sprx_front_end_inst (.mclk(mclk), .rst(rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .rxPinIn(rxPinIn),
    .rxPinOut(rxPinOut), .rxPinOe(rxPinOe), .gpoLevel(gpoLevel),
    .inputModeComparator(inputModeComparator), .routeToTx(routeToTx),
    .aifValid(aifValid), .aifReady(aifReady), .txValid(txValid),
    .txReady(txReady), .wordOut(wordOut), .rxPowered(rxPowered),
    .locked(locked), .nonPcm(nonPcm), .wordLength(wordLength),
    .overrun(overrun));
  sprx_src_model src_inst (.mclk(mclk), .line(line));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // pins, sinks, watchdog
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if ((aifValid && aifReady) || (txValid && txReady))
      got.push_back(wordOut);
    if (overrun === 1'h1)
      overruns <= overruns + 1;
    if ((aifValid && routeToTx) || (txValid && !routeToTx))
      wrongSide <= wrongSide + 1;
    aifReady <= ~stallMode[1] & (~stallMode[0] | 1'($random(seed)));
    txReady <= ~stallMode[1];
    rxPinIn <= (8'($random(seed)) & ~(8'h01 << pinSel))
      | (8'(line) << pinSel);
    if (cyc == 60000) begin
      mismatches++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e,
      input string m);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic cmpw(input sprx_subframe_type g,
      input sprx_subframe_type e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t word got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'h0;
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'h0;
    @(posedge mclk);
    #1;
    d = regRdata;
  endtask

  function automatic sprx_subframe_type expw(input logic [26:0] d,
      input int pre, input int wl);
    return '{d[23:0] & (24'hFFFFFF << (24 - wl)), d[24], d[25], d[26],
      ^d, 1'h0, pre == 2, pre == 1};
  endfunction

  task automatic sub(input int pre, input logic cs, input int wl);
    logic [26:0] d;
    d = {cs, 2'($random(seed)), 24'($random(seed))};
    expQ.push_back(expw(d, pre, wl));
    src_inst.send_sub(pre, d);
  endtask

  // channel-status length 20 and non-PCM only in blocks longer than 32
  task automatic frames(input int n, input int from);
    src_inst.kick();
    for (int f = 0; f < n; f++) begin
      sub((f == 0) ? 1 : 3, n > 32 && (f == 1 || f == 32 || f == 33),
        (f >= from) ? 20 : 24);
      sub(2, 1'($random(seed)), (f >= from) ? 20 : 24);
    end
  endtask

  // the first sub-frame after a pause may be lost while hunting
  task automatic check_tail(input int k);
    repeat (40) @(posedge mclk);
    cmp8(8'(got.size() >= k), 8'h01, "word count");
    for (int i = 1; i <= k && i <= got.size(); i++)
      cmpw(got[got.size() - i], expQ[expQ.size() - i]);
    got.delete();
    expQ.delete();
  endtask

  task automatic count(input int k);
    repeat (40) @(posedge mclk);
    cmp8(8'(got.size()), 8'(k), "words held");
    got.delete();
    expQ.delete();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'h1;
    regWrite = 1'h0;
    regRead = 1'h0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    rxPinIn = 8'h00;
    gpoLevel = 4'h0;
    routeToTx = 1'h0;
    aifReady = 1'h1;
    txReady = 1'h1;
    stallMode = 2'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    #1;
    cmp8({7'h0, rxPowered}, 8'h00, "powered at reset");
    cmp8(inputModeComparator, 8'hFF, "mode at reset");
    cmp8({7'h0, nonPcm}, 8'h00, "non pcm at reset");
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], v);
      cmp8(v, rv[i], "reset value");
    end
    r = 8'($random(seed));
    wr(OFF_INPUT_MODE, r);
    rd(OFF_INPUT_MODE, v);
    cmp8(v, r, "mode readback");
    cmp8(inputModeComparator, r, "mode port");
    gpoLevel <= 4'($random(seed));
    wr(OFF_RX_CONFIG, 8'hA5);
    rd(OFF_RX_CONFIG, v);
    cmp8(v, 8'hA0, "config readback");
    cmp8(rxPinOe, 8'hF0, "upper enables");
    cmp8(rxPinOut, {gpoLevel, 4'h0}, "upper levels");
    wr(OFF_RX_CONFIG, 8'h80);
    cmp8(rxPinOe, 8'h00, "inputs again");
    wr(OFF_POWER_DOWN, 8'h00);
    cmp8({7'h0, rxPowered}, 8'h01, "powered up");
    stallMode = 2'h1;
    for (int s = 0; s < 8; s++) begin
      wr(OFF_INPUT_SELECT, 8'(s));
      pinSel = s;
      frames(2, 99);
      check_tail(3);
      cmp8({7'h0, locked}, 8'h01, "locked after frames");
    end
    pinSel = 1;
    frames(2, 99);
    count(0);
    pinSel = 0;
    wr(OFF_INPUT_SELECT, 8'h00);
    wr(OFF_RX_CONFIG, 8'h00);
    src_inst.u1 = 2;
    frames(2, 99);
    count(0);
    wr(OFF_RX_CONFIG, 8'h80);
    frames(2, 99);
    check_tail(3);
    src_inst.u1 = 3;
    frames(40, 34);
    check_tail(10);
    cmp8({3'h0, wordLength}, 8'h14, "indicated length");
    cmp8({7'h0, nonPcm}, 8'h01, "non pcm flagged");
    wr(OFF_RX_CONFIG, 8'hC0);
    routeToTx <= 1'h1;
    frames(2, 99);
    check_tail(3);
    routeToTx <= 1'h0;
    cmp8(8'(wrongSide), 8'h00, "unrouted side idle");
    stallMode <= 2'h2;
    frames(2, 99);
    repeat (20) @(posedge mclk);
    stallMode <= 2'h0;
    count(2);
    cmp8(8'(overruns > 0), 8'h01, "lost word flagged");
    fork
      frames(2, 99);
      begin
        repeat (500) @(posedge mclk);
        wr(OFF_POWER_DOWN, 8'h02);
        cmp8({7'h0, rxPowered}, 8'h01, "on until frame end");
      end
    join
    check_tail(1);
    cmp8({7'h0, rxPowered}, 8'h00, "off after frame");
    cmp8({7'h0, locked}, 8'h00, "unlocked when off");
    end_sim();
  end
endmodule
